// ==== inc/cmm_cfg.svh ====
`ifndef CMM_CFG_SVH
`define CMM_CFG_SVH
`define CMM_PC_W 13
`define CMM_FETCH_W 10
`define CMM_RESET_VEC 13'h0000
`define CMM_IRQ_VEC 13'h0004
`define CMM_PC_ONE 13'h0001
`define CMM_SFR_TOP 7'h1f
`define CMM_GPR_BASE 7'h20
`define CMM_GPR_LAST 7'h5f
`define CMM_GPR_AW 6
`define CMM_GPR_DEPTH 64
`define CMM_STATUS_OFS 7'h03
`define CMM_FPTR_OFS 7'h04
`define CMM_PFLAGS_ADDR 8'h8e
`define CMM_TRIM_ADDR 8'h90
`define CMM_ST_BANK 5
`define CMM_ST_TO 4
`define CMM_ST_PD 3
`define CMM_ST_Z 2
`define CMM_ST_DC 1
`define CMM_ST_C 0
`define CMM_PF_POR 1
`define CMM_PF_BOD 0
`define CMM_STATUS_RST 8'h18
`define CMM_FPTR_RST 8'h00
`define CMM_PFLAGS_RST 2'h1
`define CMM_TRIM_RST 6'h20
`define CMM_TRIM_LSB 2
`define CMM_SW_ADDR 3'h0
`define CMM_SW_WDATA 3'h1
`define CMM_SW_ALU_A 3'h2
`define CMM_SW_CMD 3'h3
`define CMM_SW_RDATA 3'h4
`define CMM_SW_PC_LO 3'h5
`define CMM_SW_PC_HI 3'h6
`define CMM_CMD_WRITE 4'h1
`define CMM_CMD_READ 4'h2
`define CMM_CMD_KICK 4'h3
`define CMM_CMD_SLEEP 4'h4
`define CMM_CMD_TIMEOUT 4'h5
`define CMM_CMD_BROWNOUT 4'h6
`define CMM_CMD_STEP 4'h7
`define CMM_CMD_IRQ 4'h8
`define CMM_CMD_ADD 4'h9
`define CMM_CMD_SUB 4'ha
`define CMM_CMD_AND 4'hb
`define CMM_CMD_LOAD 4'hc
`endif

// ==== inc/cmm_pkg.sv ====
`default_nettype none
package cmm_pkg;
    typedef enum logic [1:0] {
        ALU_NONE = 2'h0,
        ALU_LOGIC = 2'h1,
        ALU_ADD = 2'h2,
        ALU_SUB = 2'h3
    } cmm_alu_t;
    typedef enum logic [2:0] {
        RG_NONE = 3'h0,
        RG_STATUS = 3'h1,
        RG_FPTR = 3'h2,
        RG_PFLAGS = 3'h3,
        RG_TRIM = 3'h4,
        RG_GPR = 3'h5
    } cmm_region_t;
endpackage
`default_nettype wire

// ==== inc/cmm_if.sv ====
`default_nettype none
interface cmm_if;
    import cmm_pkg::*;
    logic [6:0] mem_addr;
    logic mem_indirect;
    logic mem_wr;
    logic mem_rd;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic mem_rvalid;
    cmm_alu_t alu_kind;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [7:0] alu_result;
    logic pc_step;
    logic pc_load;
    logic [12:0] pc_value;
    logic irq_take;
    logic [12:0] pc;
    logic wdt_kick;
    logic sleep_op;
    logic wdt_timeout;
    logic bod_event;
    modport dev (
        input mem_addr, mem_indirect, mem_wr, mem_rd, mem_wdata,
        input alu_kind, alu_a, alu_b, alu_result,
        input pc_step, pc_load, pc_value, irq_take,
        input wdt_kick, sleep_op, wdt_timeout, bod_event,
        output mem_rdata, mem_rvalid, pc
    );
    modport core (
        output mem_addr, mem_indirect, mem_wr, mem_rd, mem_wdata,
        output alu_kind, alu_a, alu_b, alu_result,
        output pc_step, pc_load, pc_value, irq_take,
        output wdt_kick, sleep_op, wdt_timeout, bod_event,
        input mem_rdata, mem_rvalid, pc
    );
endinterface
`default_nettype wire

// ==== core/cmm_device.sv ====
// Contract
// RULE1: 13-bit counter, fetch wraps into 1K words
// RULE2: Reset starts at zero, interrupt at four
// RULE3: Two banks, low 32 are special registers
// RULE4: 20h-5Fh RAM shared by both banks
// RULE5: Unimplemented data locations read zero
// RULE6: Status bit 5 selects bank, resets zero
// RULE7: 64 byte RAM, direct or via pointer
// RULE8: Flag-updating ops ignore written Z, DC, C
// RULE9: Expired and halt bits never software written
// RULE10: Software keeps status bits 7:6 at zero; the core end clears them on direct plain writes only
// RULE11: Expired bit set by power-up, kick, sleep
// RULE12: Halt bit set by power-up/kick, cleared sleep
// RULE13: Zero flag reflects zero result
// RULE14: Nibble carry from bit 3, inverted subtract
// RULE15: Carry from top bit, inverted borrow subtract
// RULE16: Power-on flag zero until software sets it
// RULE17: Brown-out flag zero until software sets it
// RULE18: Power flags bits 7:2 read zero
// RULE19: Six-bit trim in 7:2, resets 100000
// RULE20: Status changed only by flag-neutral moves; here add, subtract and AND commands can also write it
// RULE21: Status reachable at same offset both banks
//
// Strobed register access was decided locally.
`include "cmm_cfg.svh"
`default_nettype none
module cmm_device (
    input wire logic CLK,
    input wire logic RESET,
    cmm_if.dev link,
    output logic [5:0] OSC_TRIM,
    output logic [`CMM_FETCH_W-1:0] FETCH_ADDR,
    output logic [7:0] STATUS_OUT
);
    import cmm_pkg::*;

    function automatic cmm_region_t decode(input logic [7:0] a);
        if (a[6:0] == `CMM_STATUS_OFS)
            decode = RG_STATUS; // RULE21
        else if (a[6:0] == `CMM_FPTR_OFS)
            decode = RG_FPTR;
        else if (a == `CMM_PFLAGS_ADDR)
            decode = RG_PFLAGS;
        else if (a == `CMM_TRIM_ADDR)
            decode = RG_TRIM;
        else if (a[6:0] > `CMM_SFR_TOP && a[6:0] <= `CMM_GPR_LAST)
            decode = RG_GPR; // RULE3 RULE4
        else
            decode = RG_NONE;
    endfunction

    function automatic logic [`CMM_GPR_AW-1:0] gpr_index(input logic [7:0] a);
        logic [6:0] ofs;
        ofs = a[6:0] - `CMM_GPR_BASE;
        gpr_index = ofs[`CMM_GPR_AW-1:0]; // RULE4
    endfunction

    logic [`CMM_PC_W-1:0] pc;
    logic [`CMM_PC_W-1:0] next_pc;
    logic [7:0] status;
    logic [7:0] next_status;
    logic [7:0] fptr;
    logic [7:0] next_fptr;
    logic [1:0] pflags;
    logic [1:0] next_pflags;
    logic [5:0] trim;
    logic [5:0] next_trim;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic [7:0] gpr [0:`CMM_GPR_DEPTH-1];
    logic [7:0] full_addr;
    cmm_region_t region;
    logic gpr_we;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] b_eff;
    logic carry_in;
    logic flag_z;

    // Program counter
    always_comb
    begin
        next_pc = pc;
        if (link.irq_take)
            next_pc = `CMM_IRQ_VEC; // RULE2
        else if (link.pc_load)
            next_pc = link.pc_value;
        else if (link.pc_step)
            next_pc = pc + `CMM_PC_ONE; // RULE1
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            pc <= `CMM_RESET_VEC; // RULE2
        else
            pc <= next_pc;
    end

    // Upper counter bits are kept but do not reach program memory
    assign FETCH_ADDR = pc[`CMM_FETCH_W-1:0]; // RULE1
    assign link.pc = pc;

    // Address formation and decode
    always_comb
    begin
        if (link.mem_indirect)
            full_addr = fptr; // RULE7
        else
            full_addr = {status[`CMM_ST_BANK], link.mem_addr}; // RULE6
        region = decode(full_addr);
        gpr_we = link.mem_wr && (region == RG_GPR);
    end

    // Flag arithmetic; subtraction adds the complement so both carries read as no-borrow
    always_comb
    begin
        carry_in = (link.alu_kind == ALU_SUB);
        b_eff = carry_in ? ~link.alu_b : link.alu_b;
        sum = {1'b0, link.alu_a} + {1'b0, b_eff} + {8'h00, carry_in}; // RULE15
        nib = {1'b0, link.alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in}; // RULE14
        if (link.alu_kind == ALU_LOGIC)
            flag_z = (link.alu_result == 8'h00); // RULE13
        else
            flag_z = (sum[7:0] == 8'h00); // RULE13
    end

    // Register file
    always_comb
    begin
        next_status = status;
        next_fptr = fptr;
        next_pflags = pflags;
        next_trim = trim;
        if (link.mem_wr)
        begin
            case (region)
                RG_STATUS:
                begin
                    // Reserved bits are stored as written
                    next_status[7:`CMM_ST_BANK] = link.mem_wdata[7:`CMM_ST_BANK]; // RULE9
                    if (link.alu_kind == ALU_NONE)
                        next_status[`CMM_ST_Z:0] = link.mem_wdata[`CMM_ST_Z:0];
                end
                RG_FPTR: next_fptr = link.mem_wdata;
                RG_PFLAGS: next_pflags = link.mem_wdata[1:0];
                RG_TRIM: next_trim = link.mem_wdata[7:`CMM_TRIM_LSB];
                default: next_status = next_status;
            endcase
        end
        // Flags from the operation override any write to them
        if (link.alu_kind != ALU_NONE)
            next_status[`CMM_ST_Z] = flag_z; // RULE8 RULE13
        if (link.alu_kind == ALU_ADD || link.alu_kind == ALU_SUB)
        begin
            next_status[`CMM_ST_DC] = nib[4]; // RULE8 RULE14
            next_status[`CMM_ST_C] = sum[8]; // RULE8 RULE15
        end
        if (link.wdt_kick)
        begin
            next_status[`CMM_ST_TO] = 1'b1; // RULE11
            next_status[`CMM_ST_PD] = 1'b1; // RULE12
        end
        if (link.sleep_op)
        begin
            next_status[`CMM_ST_TO] = 1'b1; // RULE11
            next_status[`CMM_ST_PD] = 1'b0; // RULE12
        end
        // A time-out in the same cycle as a kick still counts
        if (link.wdt_timeout)
            next_status[`CMM_ST_TO] = 1'b0; // RULE11
        // Hardware clear wins over a software set in the same cycle
        if (link.bod_event)
            next_pflags[`CMM_PF_BOD] = 1'b0; // RULE17
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            status <= `CMM_STATUS_RST; // RULE6 RULE11 RULE12
            fptr <= `CMM_FPTR_RST;
            pflags <= `CMM_PFLAGS_RST; // RULE16 RULE18
            trim <= `CMM_TRIM_RST; // RULE19
        end
        else
        begin
            status <= next_status;
            fptr <= next_fptr;
            pflags <= next_pflags;
            trim <= next_trim;
        end
    end

    // RAM has no reset; contents are undefined until written
    always_ff @(posedge CLK)
    begin
        if (gpr_we)
            gpr[gpr_index(full_addr)] <= link.mem_wdata; // RULE4 RULE7
    end

    // Read path, data one cycle after the strobe
    always_comb
    begin
        next_rvalid = link.mem_rd;
        next_rdata = 8'h00; // RULE5
        if (link.mem_rd)
        begin
            case (region)
                RG_STATUS: next_rdata = status;
                RG_FPTR: next_rdata = fptr;
                RG_PFLAGS: next_rdata = {6'h00, pflags}; // RULE18
                RG_TRIM: next_rdata = {trim, 2'h0}; // RULE19
                RG_GPR: next_rdata = gpr[gpr_index(full_addr)]; // RULE4
                default: next_rdata = 8'h00; // RULE5
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end
        else
        begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign link.mem_rdata = rdata;
    assign link.mem_rvalid = rvalid;
    assign OSC_TRIM = trim; // RULE19
    assign STATUS_OUT = status;
endmodule // cmm_device
`default_nettype wire

// ==== core/cmm_core_end.sv ====
`include "cmm_cfg.svh"
`default_nettype none
module cmm_core_end (
    input wire logic CLK,
    input wire logic RESET,
    cmm_if.core link,
    input wire logic [2:0] SW_ADDR,
    input wire logic [7:0] SW_WDATA,
    input wire logic SW_WR,
    input wire logic SW_RD,
    output logic [7:0] SW_RDATA
);
    import cmm_pkg::*;

    logic [7:0] addr_reg;
    logic [7:0] next_addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] next_wdata_reg;
    logic [7:0] alu_a_reg;
    logic [7:0] next_alu_a_reg;
    logic [7:0] rd_hold;
    logic [7:0] next_rd_hold;
    logic [7:0] sw_rdata;
    logic [7:0] next_sw_rdata;
    logic [6:0] mem_addr;
    logic [6:0] next_mem_addr;
    logic mem_indirect;
    logic next_mem_indirect;
    logic [7:0] mem_wdata;
    logic [7:0] next_mem_wdata;
    logic [7:0] alu_b;
    logic [7:0] next_alu_b;
    logic [7:0] alu_a;
    logic [7:0] next_alu_a;
    logic [12:0] pc_value;
    logic [12:0] next_pc_value;
    cmm_alu_t alu_kind;
    cmm_alu_t next_alu_kind;
    logic [8:0] pulse;
    logic [8:0] next_pulse;
    logic cmd;
    logic [7:0] safe_wdata;

    assign cmd = SW_WR && (SW_ADDR == `CMM_SW_CMD);

    always_comb
    begin
        next_addr_reg = addr_reg;
        next_wdata_reg = wdata_reg;
        next_alu_a_reg = alu_a_reg;
        next_mem_addr = mem_addr;
        next_mem_indirect = mem_indirect;
        next_mem_wdata = mem_wdata;
        next_alu_a = alu_a;
        next_alu_b = alu_b;
        next_pc_value = pc_value;
        next_alu_kind = ALU_NONE;
        next_pulse = 9'h000;
        next_rd_hold = link.mem_rvalid ? link.mem_rdata : rd_hold;
        // Status stores reserved bits as given, so this end clears them on direct plain writes
        safe_wdata = wdata_reg;
        if (addr_reg[6:0] == `CMM_STATUS_OFS && !addr_reg[7])
            safe_wdata[7:6] = 2'h0; // RULE10
        if (SW_WR && SW_ADDR == `CMM_SW_ADDR)
            next_addr_reg = SW_WDATA;
        if (SW_WR && SW_ADDR == `CMM_SW_WDATA)
            next_wdata_reg = SW_WDATA;
        if (SW_WR && SW_ADDR == `CMM_SW_ALU_A)
            next_alu_a_reg = SW_WDATA;
        if (cmd)
        begin
            next_mem_addr = addr_reg[6:0];
            next_mem_indirect = addr_reg[7];
            next_alu_a = alu_a_reg;
            next_alu_b = wdata_reg;
            case (SW_WDATA[3:0])
                // Plain move leaves flags alone, so status takes Z, DC and C as written
                `CMM_CMD_WRITE:
                begin
                    next_pulse[0] = 1'b1; // RULE20 RULE16 RULE17
                    next_mem_wdata = safe_wdata;
                end
                `CMM_CMD_READ: next_pulse[1] = 1'b1;
                `CMM_CMD_KICK: next_pulse[2] = 1'b1;
                `CMM_CMD_SLEEP: next_pulse[3] = 1'b1;
                `CMM_CMD_TIMEOUT: next_pulse[4] = 1'b1;
                `CMM_CMD_BROWNOUT: next_pulse[5] = 1'b1;
                `CMM_CMD_STEP: next_pulse[6] = 1'b1;
                `CMM_CMD_IRQ: next_pulse[7] = 1'b1;
                `CMM_CMD_LOAD:
                begin
                    next_pulse[8] = 1'b1;
                    next_pc_value = {alu_a_reg[4:0], wdata_reg};
                end
                `CMM_CMD_ADD:
                begin
                    next_pulse[0] = 1'b1;
                    next_alu_kind = ALU_ADD;
                    next_mem_wdata = alu_a_reg + wdata_reg;
                end
                `CMM_CMD_SUB:
                begin
                    next_pulse[0] = 1'b1;
                    next_alu_kind = ALU_SUB;
                    next_mem_wdata = alu_a_reg - wdata_reg;
                end
                `CMM_CMD_AND:
                begin
                    next_pulse[0] = 1'b1;
                    next_alu_kind = ALU_LOGIC;
                    next_mem_wdata = alu_a_reg & wdata_reg;
                end
                default: next_pulse = 9'h000;
            endcase
        end
        next_sw_rdata = 8'h00;
        if (SW_RD)
        begin
            case (SW_ADDR)
                `CMM_SW_ADDR: next_sw_rdata = addr_reg;
                `CMM_SW_WDATA: next_sw_rdata = wdata_reg;
                `CMM_SW_ALU_A: next_sw_rdata = alu_a_reg;
                `CMM_SW_RDATA: next_sw_rdata = rd_hold;
                `CMM_SW_PC_LO: next_sw_rdata = link.pc[7:0];
                `CMM_SW_PC_HI: next_sw_rdata = {3'h0, link.pc[12:8]};
                default: next_sw_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            alu_a_reg <= 8'h00;
            rd_hold <= 8'h00;
            sw_rdata <= 8'h00;
            mem_addr <= 7'h00;
            mem_indirect <= 1'b0;
            mem_wdata <= 8'h00;
            alu_a <= 8'h00;
            alu_b <= 8'h00;
            pc_value <= 13'h0000;
            alu_kind <= ALU_NONE;
            pulse <= 9'h000;
        end
        else
        begin
            addr_reg <= next_addr_reg;
            wdata_reg <= next_wdata_reg;
            alu_a_reg <= next_alu_a_reg;
            rd_hold <= next_rd_hold;
            sw_rdata <= next_sw_rdata;
            mem_addr <= next_mem_addr;
            mem_indirect <= next_mem_indirect;
            mem_wdata <= next_mem_wdata;
            alu_a <= next_alu_a;
            alu_b <= next_alu_b;
            pc_value <= next_pc_value;
            alu_kind <= next_alu_kind;
            pulse <= next_pulse;
        end
    end

    assign link.mem_addr = mem_addr;
    assign link.mem_indirect = mem_indirect;
    assign link.mem_wdata = mem_wdata;
    assign link.alu_a = alu_a;
    assign link.alu_b = alu_b;
    assign link.alu_result = mem_wdata;
    assign link.alu_kind = alu_kind;
    assign link.pc_value = pc_value;
    assign link.mem_wr = pulse[0];
    assign link.mem_rd = pulse[1];
    assign link.wdt_kick = pulse[2];
    assign link.sleep_op = pulse[3];
    assign link.wdt_timeout = pulse[4];
    assign link.bod_event = pulse[5];
    assign link.pc_step = pulse[6];
    assign link.irq_take = pulse[7];
    assign link.pc_load = pulse[8];
    assign SW_RDATA = sw_rdata;
endmodule // cmm_core_end
`default_nettype wire

// ==== testbench/cmm_props.sv ====
`default_nettype none
module cmm_props (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [6:0] mem_addr,
    input wire logic mem_indirect,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    input wire cmm_pkg::cmm_alu_t alu_kind,
    input wire logic pc_step,
    input wire logic pc_load,
    input wire logic [12:0] pc_value,
    input wire logic irq_take,
    input wire logic [12:0] pc
);
    timeunit 1ns;
    timeprecision 1ps;
    import cmm_pkg::*;
    logic [6:0] ram_addr;
    logic [7:0] ram_data;
    logic ram_valid;
    logic [6:0] next_ram_addr;
    logic [7:0] next_ram_data;
    logic next_ram_valid;
    // Only the last direct RAM write is tracked; enough to see the bank mirror
    always_comb
    begin
        next_ram_addr = ram_addr;
        next_ram_data = ram_data;
        next_ram_valid = ram_valid;
        // A pointer write may land on the tracked byte, so stop trusting it
        if (mem_wr && mem_indirect)
            next_ram_valid = 1'b0;
        // Results of arithmetic land in RAM as well, so they are tracked too
        if (mem_wr && !mem_indirect && mem_addr inside {[7'h20:7'h5f]})
        begin
            next_ram_addr = mem_addr;
            next_ram_data = mem_wdata;
            next_ram_valid = 1'b1;
        end
    end
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ram_addr <= 7'h00;
            ram_data <= 8'h00;
            ram_valid <= 1'b0;
        end
        else
        begin
            ram_addr <= next_ram_addr;
            ram_data <= next_ram_data;
            ram_valid <= next_ram_valid;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    sequence s_direct_rd;
        mem_rd && !mem_indirect;
    endsequence
    sequence s_step_only;
        pc_step && !pc_load && !irq_take;
    endsequence
    a_read_answer: assert property (mem_rd |=> mem_rvalid)
        else $error("read not answered next cycle");
    a_rvalid_cause: assert property (mem_rvalid |-> $past(mem_rd))
        else $error("read answer without request");
    a_unimpl_zero: assert property (s_direct_rd ##0 mem_addr > 7'h5f |=> mem_rdata == 8'h00)
        else $error("unimplemented location not zero");
    a_sfr_gap_zero: assert property (s_direct_rd ##0 mem_addr inside {[7'h00:7'h02],
        [7'h05:7'h0d], [7'h11:7'h1f]} |=> mem_rdata == 8'h00)
        else $error("empty special location not zero");
    a_ram_mirror: assert property (s_direct_rd ##0 (ram_valid && mem_addr == ram_addr)
        |=> mem_rdata == ram_data) else $error("ram readback differs");
    a_irq_vector: assert property (irq_take |=> pc == 13'h0004)
        else $error("interrupt vector wrong");
    a_pc_load: assert property (pc_load && !irq_take |=> pc == $past(pc_value))
        else $error("counter load wrong");
    a_pc_step: assert property (s_step_only |=> pc == $past(pc) + 13'h0001)
        else $error("counter step wrong");
    a_pc_hold: assert property (!pc_step && !pc_load && !irq_take |=> $stable(pc))
        else $error("counter moved unasked");
endmodule // cmm_props
`default_nettype wire

// ==== testbench/testbench.sv ====
`include "cmm_cfg.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import cmm_pkg::*;
    logic CLK, RESET, SW_WR, SW_RD;
    logic [2:0] SW_ADDR;
    logic [7:0] SW_WDATA, SW_RDATA, STATUS_OUT;
    logic [5:0] OSC_TRIM;
    logic [9:0] FETCH_ADDR;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    // kind, operand a, operand b, expected status
    localparam logic [31:0] ALU_TAB [6] = '{32'h09060118, 32'h090f011a, 32'h09ff011f,
        32'h0a100119, 32'h0a05051f, 32'h0b0f031b};
    cmm_if u_cmm_if ();
    cmm_device u_cmm_device (.CLK(CLK), .RESET(RESET), .link(u_cmm_if), .OSC_TRIM(OSC_TRIM),
        .FETCH_ADDR(FETCH_ADDR), .STATUS_OUT(STATUS_OUT));
    cmm_core_end u_cmm_core_end (.CLK(CLK), .RESET(RESET), .link(u_cmm_if), .SW_ADDR(SW_ADDR),
        .SW_WDATA(SW_WDATA), .SW_WR(SW_WR), .SW_RD(SW_RD), .SW_RDATA(SW_RDATA));
    cmm_props u_cmm_props (.CLK(CLK), .RESET(RESET), .mem_addr(u_cmm_if.mem_addr),
        .mem_indirect(u_cmm_if.mem_indirect), .mem_wr(u_cmm_if.mem_wr),
        .mem_rd(u_cmm_if.mem_rd), .mem_wdata(u_cmm_if.mem_wdata),
        .mem_rdata(u_cmm_if.mem_rdata), .mem_rvalid(u_cmm_if.mem_rvalid),
        .alu_kind(u_cmm_if.alu_kind), .pc_step(u_cmm_if.pc_step), .pc_load(u_cmm_if.pc_load),
        .pc_value(u_cmm_if.pc_value), .irq_take(u_cmm_if.irq_take), .pc(u_cmm_if.pc));
    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    task automatic results;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            err_count++;
            results;
        end
    end
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("BAD %0t value %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic st(input logic [7:0] e);
        chk({2'h0, STATUS_OUT}, {2'h0, e});
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        SW_ADDR <= a;
        SW_WDATA <= d;
        SW_WR <= 1'b1;
        @(posedge CLK);
        SW_WR <= 1'b0;
        @(posedge CLK);
    endtask
    // Settles well past the two cycles a command needs to reach the far end
    task automatic cmd(input logic [3:0] c);
        wr(3'h3, {4'h0, c});
        repeat (3) @(posedge CLK);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        SW_ADDR <= a;
        SW_RD <= 1'b1;
        @(posedge CLK);
        SW_RD <= 1'b0;
        #1 chk({2'h0, SW_RDATA}, {2'h0, e});
        @(posedge CLK);
    endtask
    task automatic mwr(input logic [7:0] a, input logic [7:0] d);
        wr(3'h0, a);
        wr(3'h1, d);
        cmd(`CMM_CMD_WRITE);
    endtask
    task automatic mrd(input logic [7:0] a, input logic [7:0] e);
        wr(3'h0, a);
        cmd(`CMM_CMD_READ);
        rd(3'h4, e);
    endtask
    task automatic pcset(input logic [7:0] hi, input logic [7:0] lo);
        wr(3'h2, hi);
        wr(3'h1, lo);
        cmd(`CMM_CMD_LOAD);
    endtask
    initial
    begin
        SW_ADDR <= 3'h0;
        SW_WDATA <= 8'h00;
        SW_WR <= 1'b0;
        SW_RD <= 1'b0;
        RESET <= 1'b1;
        repeat (4) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        st(8'h18);
        chk({4'h0, OSC_TRIM}, 10'h020);
        chk(FETCH_ADDR, 10'h000);
        rd(3'h5, 8'h00);
        mrd(8'h0e, 8'h00);
        mrd(8'h05, 8'h00);
        mwr(8'h20, 8'ha5);
        mwr(8'h60, 8'h5a);
        mrd(8'h60, 8'h00);
        mwr(8'h03, 8'he0);
        st(8'h38);
        mrd(8'h20, 8'ha5);
        mwr(8'h5f, 8'h3c);
        mrd(8'h0e, 8'h01);
        mwr(8'h0e, 8'hff);
        mrd(8'h0e, 8'h03);
        cmd(`CMM_CMD_BROWNOUT);
        mrd(8'h0e, 8'h02);
        mwr(8'h10, 8'h57);
        mrd(8'h10, 8'h54);
        chk({4'h0, OSC_TRIM}, 10'h015);
        mrd(8'h03, 8'h38);
        mwr(8'h03, 8'h00);
        st(8'h18);
        mrd(8'h5f, 8'h3c);
        mwr(8'h04, 8'h21);
        mwr(8'h80, 8'h77);
        mrd(8'h21, 8'h77);
        mrd(8'h80, 8'h77);
        for (int i = 0; i < 6; i++)
        begin
            wr(3'h0, 8'h03);
            wr(3'h2, ALU_TAB[i][23:16]);
            wr(3'h1, ALU_TAB[i][15:8]);
            cmd(ALU_TAB[i][27:24]);
            st(ALU_TAB[i][7:0]);
        end
        cmd(`CMM_CMD_SLEEP);
        st(8'h13);
        cmd(`CMM_CMD_TIMEOUT);
        st(8'h03);
        cmd(`CMM_CMD_KICK);
        st(8'h1b);
        cmd(`CMM_CMD_SLEEP);
        mwr(8'h03, 8'h18);
        st(8'h10);
        pcset(8'h1f, 8'hfe);
        chk(FETCH_ADDR, 10'h3fe);
        rd(3'h6, 8'h1f);
        cmd(`CMM_CMD_STEP);
        chk(FETCH_ADDR, 10'h3ff);
        cmd(`CMM_CMD_STEP);
        chk(FETCH_ADDR, 10'h000);
        pcset(8'h04, 8'h00);
        chk(FETCH_ADDR, 10'h000);
        rd(3'h6, 8'h04);
        cmd(`CMM_CMD_IRQ);
        chk(FETCH_ADDR, 10'h004);
        rd(3'h5, 8'h04);
        // Second reset from a state where pc, status, fptr, power flags and trim all differ from their reset values
        RESET <= 1'b1;
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        chk(FETCH_ADDR, 10'h000);
        st(8'h18);
        chk({4'h0, OSC_TRIM}, 10'h020);
        rd(3'h6, 8'h00);
        mwr(8'h04, 8'h8e);
        mrd(8'h80, 8'h01);
        results;
    end
endmodule // testbench
`default_nettype wire
